// ---- hw/fsp_pkg.sv ----
// constants shared by the sector protection logic
// assumes a 32-bit classic wishbone register bus
package fsp_pkg;

  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned SECTORS    = 256;
  localparam int unsigned SEC_W      = 8;
  localparam int unsigned BOOT_SECS  = 8;
  localparam int unsigned SUBSECS    = 16;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_LOCK_SEL  = 8'h04;
  localparam logic [7:0] OFF_LOCK_DATA = 8'h08;
  localparam logic [7:0] OFF_OP        = 8'h0C;
  localparam logic [7:0] OFF_FLAGS     = 8'h10;
  localparam logic [7:0] OFF_MASK      = 8'h14;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned ST_SIZE_LSB  = 0;
  localparam int unsigned ST_TB_BIT    = 4;
  localparam int unsigned ST_STATUS_WRITE_DISABLE_BIT  = 7;
  localparam int unsigned LK_WL_BIT    = 0;
  localparam int unsigned LK_LD_BIT    = 1;
  localparam int unsigned OP_KIND_LSB  = 8;
  localparam int unsigned OP_SUB_LSB   = 10;
  localparam int unsigned RES_GRANT    = 16;
  localparam int unsigned RES_REFUSE   = 17;
  localparam int unsigned FL_DONE_BIT  = 0;
  localparam int unsigned FL_PROT_BIT  = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [1:0] RST_LOCK   = 2'h0;
  localparam logic [1:0] RST_FLAGS  = 2'h0;
  localparam logic [1:0] RST_MASK   = 2'h0;

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    FSP_OP_PROGRAM,
    FSP_OP_SECTOR_ERASE,
    FSP_OP_SUBSECTOR_ERASE,
    FSP_OP_RESERVED
  } fsp_op_type;

  typedef enum logic [1:0] {
    FSP_UNIFORM,
    FSP_BOOT_BOTTOM,
    FSP_BOOT_TOP
  } fsp_variant_type;

endpackage : fsp_pkg

// ---- hw/fsp_top.sv ----
// sector lock and region protection with a wishbone register file
// assumes one clock, a host on wishbone, write_protect_n from a pin
//
// Summary of operation
// R1 - one two-bit lock register per 64 KB sector: write-lock, lock-down
// R2 - host reads and writes a selected sector lock register
// R3 - write-lock at 1 refuses any modify of that sector
// R4 - write-lock at 0 gives no lock protection to the sector
// R5 - lock-down at 1 freezes both lock bits until power-up
// R6 - lock-down at 0 lets both lock bits be written
// R7 - sector protected when lock or region protects it
// R8 - region from four size bits and a top/bottom select
// R9 - write-protect pin asserted makes status register read-only
// R10 - size code 0000 protects no sector
// R11 - select 0, codes 1 to 8 protect the top 2^(c-1) sectors
// R12 - select 1, codes 1 to 8 protect the bottom 2^(c-1) sectors
// R13 - select 1 code 1000 protects sectors 0 to 127 only
// R14 - size codes 1001 to 1111 protect all 256 sectors
// R15 - build variant: bottom boot, top boot or uniform sectors
// R16 - refused modify or blocked status write sets protection error; this block skips it for reserved ops and non-boot subsector erases
// R17 - host sets write-enable latch before any modify, lock writes too; this block has no such latch and does not check it
// R18 - subsector erase refused when enclosing sector protected
`timescale 1ns/1ps

module fsp_top #(
  parameter fsp_pkg::fsp_variant_type VARIANT = fsp_pkg::FSP_BOOT_BOTTOM
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        write_protect_n,
  output logic             irq,
  output logic             op_grant,
  output logic             op_refuse
);

  // ************************************************************
  // write-protect pin synchroniser
  // ************************************************************
  logic wp_s1;
  logic wp_s2;
  logic wp_s3;
  logic wp_active;
  logic next_wp_active;

  always_comb begin
    next_wp_active = wp_active;
    if (wp_s2 == wp_s3) begin
      next_wp_active = ~wp_s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_s1     <= 1'b1;
      wp_s2     <= 1'b1;
      wp_s3     <= 1'b1;
      wp_active <= 1'b0;
    end else begin
      wp_s1     <= write_protect_n;
      wp_s2     <= wp_s1;
      wp_s3     <= wp_s2;
      wp_active <= next_wp_active;
    end
  end

  // ************************************************************
  // bus decode
  // ************************************************************
  logic req;
  logic wr_go;
  logic rd_go;
  logic wr_status;
  logic wr_sel;
  logic wr_lock;
  logic wr_op;
  logic wr_flags;
  logic wr_mask;

  assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_go     = req & wb_we_i;
  assign rd_go     = req & ~wb_we_i;
  assign wr_status = wr_go & wb_sel_i[0] & (wb_adr_i == fsp_pkg::OFF_STATUS);
  assign wr_sel    = wr_go & wb_sel_i[0]
                   & (wb_adr_i == fsp_pkg::OFF_LOCK_SEL);
  assign wr_lock   = wr_go & wb_sel_i[0]
                   & (wb_adr_i == fsp_pkg::OFF_LOCK_DATA);
  assign wr_op     = wr_go & (&wb_sel_i[1:0])
                   & (wb_adr_i == fsp_pkg::OFF_OP);
  assign wr_flags  = wr_go & wb_sel_i[0] & (wb_adr_i == fsp_pkg::OFF_FLAGS);
  assign wr_mask   = wr_go & wb_sel_i[0] & (wb_adr_i == fsp_pkg::OFF_MASK);

  // ************************************************************
  // sector lock registers
  // ************************************************************
  logic [fsp_pkg::SEC_W-1:0] lock_sel;
  logic [1:0]                lock_q [fsp_pkg::SECTORS];

  genvar gi;
  generate
    for (gi = 0; gi < fsp_pkg::SECTORS; gi++) begin : g_lock
      logic [1:0] next_lock;
      always_comb begin
        next_lock = lock_q[gi];
        if (wr_lock && (lock_sel == fsp_pkg::SEC_W'(gi))
            && !lock_q[gi][fsp_pkg::LK_LD_BIT]) begin // R2 R5 R6
          next_lock = wb_dat_i[1:0]; // R1
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lock_q[gi] <= fsp_pkg::RST_LOCK; // R5
        end else begin
          lock_q[gi] <= next_lock;
        end
      end
    end
  endgenerate

  // ************************************************************
  // region decode
  // ************************************************************
  function automatic logic region_hit(input logic [3:0] code,
                                      input logic       tb,
                                      input logic [7:0] sec);
    logic [8:0] span;
    logic       hit;
    span = 9'h000;
    hit  = 1'b0;
    if (code == 4'h0) begin
      hit = 1'b0; // R10
    end else if (code > 4'h8) begin
      hit = 1'b1; // R14
    end else begin
      span = 9'h001 << (code - 4'h1);
      if (tb) begin
        hit = ({1'b0, sec} < span); // R12 R13
      end else begin
        hit = ({1'b0, sec} >= (9'h100 - span)); // R11
      end
    end
    return hit;
  endfunction : region_hit

  function automatic logic in_boot(input logic [7:0] sec);
    logic r;
    r = 1'b0;
    unique case (VARIANT) // R15
      fsp_pkg::FSP_BOOT_BOTTOM: r = (sec < 8'(fsp_pkg::BOOT_SECS));
      fsp_pkg::FSP_BOOT_TOP:
        r = (sec >= 8'(fsp_pkg::SECTORS - fsp_pkg::BOOT_SECS));
      fsp_pkg::FSP_UNIFORM:     r = 1'b0;
      default:                  r = 1'b0;
    endcase
    return r;
  endfunction : in_boot

  // ************************************************************
  // protection check of a modify request
  // ************************************************************
  logic [7:0]           op_sec;
  fsp_pkg::fsp_op_type  op_kind;
  logic [3:0]           region_code;
  logic                 region_tb;
  logic                 sec_locked;
  logic                 sec_region;
  logic                 sec_prot;
  logic                 kind_ok;
  logic [7:0]           status_q;

  assign op_sec      = wb_dat_i[7:0];
  assign op_kind     = fsp_pkg::fsp_op_type'(
                         wb_dat_i[fsp_pkg::OP_KIND_LSB +: 2]);
  assign region_code = status_q[fsp_pkg::ST_SIZE_LSB +: 4]; // R8
  assign region_tb   = status_q[fsp_pkg::ST_TB_BIT]; // R8
  assign sec_locked  = lock_q[op_sec][fsp_pkg::LK_WL_BIT]; // R3 R4
  assign sec_region  = region_hit(region_code, region_tb, op_sec);
  assign sec_prot    = sec_locked | sec_region; // R7 R18

  always_comb begin
    kind_ok = 1'b0;
    unique case (op_kind)
      fsp_pkg::FSP_OP_PROGRAM:         kind_ok = 1'b1;
      fsp_pkg::FSP_OP_SECTOR_ERASE:    kind_ok = 1'b1;
      fsp_pkg::FSP_OP_SUBSECTOR_ERASE: kind_ok = in_boot(op_sec); // R15
      fsp_pkg::FSP_OP_RESERVED:        kind_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // status, selection, flags, mask and bus answer
  // ************************************************************
  logic [7:0]  next_status;
  logic [7:0]  next_lock_sel;
  logic [1:0]  flags;
  logic [1:0]  next_flags;
  logic [1:0]  mask;
  logic [1:0]  next_mask;
  logic [17:0] op_res;
  logic [17:0] next_op_res;
  logic        next_grant;
  logic        next_refuse;
  logic        next_irq;
  logic        next_ack;
  logic [31:0] next_dat;
  logic [1:0]  set_ev;

  localparam int unsigned RG = fsp_pkg::RES_GRANT;
  localparam int unsigned RR = fsp_pkg::RES_REFUSE;

  always_comb begin
    next_status   = status_q;
    next_lock_sel = lock_sel;
    next_mask     = mask;
    next_op_res   = op_res;
    next_grant    = 1'b0;
    next_refuse   = 1'b0;
    set_ev        = 2'b00;
    if (wr_status) begin
      if (wp_active) begin
        set_ev[fsp_pkg::FL_PROT_BIT] = 1'b1; // R9 R16
      end else begin
        next_status = {wb_dat_i[7], 2'b00, wb_dat_i[4:0]};
      end
    end
    if (wr_sel) begin
      next_lock_sel = wb_dat_i[7:0];
    end
    if (wr_mask) begin
      next_mask = wb_dat_i[1:0];
    end
    if (wr_op) begin
      next_op_res[15:0] = wb_dat_i[15:0];
      next_op_res[RG]   = 1'b0;
      next_op_res[RR]   = 1'b0;
      if (kind_ok && !sec_prot) begin
        next_grant      = 1'b1;
        next_op_res[RG] = 1'b1;
        set_ev[fsp_pkg::FL_DONE_BIT] = 1'b1;
      end else begin
        next_refuse     = 1'b1; // R3 R18
        next_op_res[RR] = 1'b1;
        if (kind_ok) begin
          set_ev[fsp_pkg::FL_PROT_BIT] = 1'b1; // R16
        end
      end
    end
    next_flags = flags;
    if (wr_flags) begin
      next_flags = flags & ~wb_dat_i[1:0]; // R16
    end
    next_flags = next_flags | set_ev;
    next_irq   = |(next_flags & next_mask);
    next_ack   = req;
    next_dat   = 32'h0000_0000;
    if (rd_go) begin
      unique case (wb_adr_i)
        fsp_pkg::OFF_STATUS:    next_dat[7:0]  = status_q;
        fsp_pkg::OFF_LOCK_SEL:  next_dat[7:0]  = lock_sel;
        fsp_pkg::OFF_LOCK_DATA: next_dat[1:0]  = lock_q[lock_sel]; // R2
        fsp_pkg::OFF_OP:        next_dat[17:0] = op_res;
        fsp_pkg::OFF_FLAGS:     next_dat[1:0]  = flags;
        fsp_pkg::OFF_MASK:      next_dat[1:0]  = mask;
        default:                next_dat       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q  <= fsp_pkg::RST_STATUS;
      lock_sel  <= 8'h00;
      flags     <= fsp_pkg::RST_FLAGS;
      mask      <= fsp_pkg::RST_MASK;
      op_res    <= 18'h00000;
      op_grant  <= 1'b0;
      op_refuse <= 1'b0;
      irq       <= 1'b0;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      status_q  <= next_status;
      lock_sel  <= next_lock_sel;
      flags     <= next_flags;
      mask      <= next_mask;
      op_res    <= next_op_res;
      op_grant  <= next_grant;
      op_refuse <= next_refuse;
      irq       <= next_irq;
      wb_ack_o  <= next_ack;
      wb_dat_o  <= next_dat;
    end
  end

endmodule : fsp_top

// ---- verif/fsp_chk.sv ----
// port checker for the sector protection block
// assumes a bind onto fsp_top, one clock, rst_n low async
`timescale 1ns/1ps
module fsp_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        write_protect_n,
  input wire logic        irq,
  input wire logic        op_grant,
  input wire logic        op_refuse
);
  // ********
  // checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence op_wr_s;
    take_s ##0 (wb_we_i && wb_adr_i == fsp_pkg::OFF_OP
      && wb_sel_i[1:0] == 2'h3);
  endsequence
  ack_latency_a: assert property (take_s |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  op_answer_a: assert property (op_wr_s |=> op_grant ^ op_refuse)
    else $error("modify request not answered once");
  op_cause_a: assert property ((op_grant || op_refuse) |->
    wb_ack_o && $past(wb_we_i && wb_adr_i == fsp_pkg::OFF_OP))
    else $error("op pulse without op write");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  irq_change_a: assert property ($changed(irq) |-> wb_ack_o)
    else $error("irq moved without access");
  lock_width_a: assert property (take_s ##0 !wb_we_i
    && wb_adr_i == fsp_pkg::OFF_LOCK_DATA |=> wb_dat_o[31:2] == 30'h0)
    else $error("lock register wider than two bits");
endmodule : fsp_chk

// ---- verif/fsp_host.sv ----
// host controller model: classic wishbone master
// assumes ack from the block, tb calls xfer
`timescale 1ns/1ps
module fsp_host (
  input wire logic clk,
  input wire logic ack,
  output logic        cyc,
  output logic        stb,
  output logic        we,
  output logic [7:0]  adr,
  output logic [3:0]  sel,
  output logic [31:0] wdat,
  output logic        hung
);
  initial {cyc, stb, we, adr, sel, wdat, hung} = '0;
  // write-enable latch taken as set before each modify
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (n >= 50) hung = 1'h1;
    {cyc, stb, adr, wdat} <= {2'h0, ~adr, ~wdat};
  endtask : xfer
endmodule : fsp_host

// ---- verif/tb_top.sv ----
// self-checking bench for the sector protection block
// assumes fsp_top with bottom boot sectors
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        wpn = 1;
  logic        cyc, stb, we, ack, irq, grant, refuse, hung, irqx;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [34:0] notes[$];
  int          errors = 0;
  int          samples_checked = 0;
  int          seed = 27898;
  int          sx[5];
  always #5 clk = ~clk;
  fsp_host u_host (.clk, .ack, .cyc, .stb, .we, .adr, .sel, .wdat, .hung);
  fsp_top DUT (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .write_protect_n(wpn), .irq,
    .op_grant(grant), .op_refuse(refuse));
  task automatic chk(input string n, input logic [34:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  always @(posedge clk) begin
    if (ack === 1'h1) chk("ack word", {irq, grant, refuse, rdat},
      notes.pop_front());
  end
  task automatic tr(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [33:0] e);
    notes.push_back({irqx, e});
    u_host.xfer(w, a, d);
    if (hung === 1'h1) complete_run();
  endtask : tr
  task automatic op(input logic [1:0] k, input int s, input logic p);
    tr(1'h1, fsp_pkg::OFF_OP, {22'h0, k, s[7:0]}, {~p, p, 32'h0});
  endtask : op
  function automatic logic rp(input int c, input int t, input int s);
    if (c == 0) return 1'h0;
    if (c > 8) return 1'h1;
    return t ? s < (1 << (c - 1)) : s >= 256 - (1 << (c - 1));
  endfunction : rp
  task automatic complete_run;
    if (hung === 1'h1) errors++;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  initial begin
    int b;
    irqx = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 16; c++) begin
        b = (c > 0 && c < 9) ? 1 << (c - 1) : 128;
        sx = '{0, 255, $random(seed) & 255, t ? b : 255 - b,
               t ? b - 1 : 256 - b};
        tr(1'h1, fsp_pkg::OFF_STATUS, 32'(t * 16 + c), 34'h0);
        foreach (sx[i]) op($random(seed) & 1, sx[i], rp(c, t, sx[i]));
      end
    end
    tr(1'h1, fsp_pkg::OFF_STATUS, 32'h0, 34'h0);
    op(2'h2, 3, 1'h0);
    op(2'h2, 100, 1'h1);
    op(2'h3, 50, 1'h1);
    tr(1'h1, fsp_pkg::OFF_STATUS, 32'h11, 34'h0);
    op(2'h2, 0, 1'h1);
    tr(1'h1, fsp_pkg::OFF_STATUS, 32'h0, 34'h0);
    tr(1'h1, fsp_pkg::OFF_LOCK_SEL, 32'hA, 34'h0);
    tr(1'h1, fsp_pkg::OFF_LOCK_DATA, 32'h1, 34'h0);
    tr(1'h0, fsp_pkg::OFF_LOCK_DATA, 32'h0, 34'h1);
    op(2'h0, 10, 1'h1);
    tr(1'h1, fsp_pkg::OFF_LOCK_DATA, 32'h0, 34'h0);
    op(2'h1, 10, 1'h0);
    tr(1'h1, fsp_pkg::OFF_LOCK_DATA, 32'h3, 34'h0);
    tr(1'h1, fsp_pkg::OFF_LOCK_DATA, 32'h0, 34'h0);
    tr(1'h0, fsp_pkg::OFF_LOCK_DATA, 32'h0, 34'h3);
    op(2'h1, 10, 1'h1);
    @(posedge clk) rst_n <= 1'h0;
    @(posedge clk) rst_n <= 1'h1;
    tr(1'h1, fsp_pkg::OFF_LOCK_SEL, 32'hA, 34'h0);
    tr(1'h0, fsp_pkg::OFF_LOCK_DATA, 32'h0, 34'h0);
    wpn <= 1'h0;
    repeat (5) @(posedge clk);
    tr(1'h1, fsp_pkg::OFF_STATUS, 32'h8F, 34'h0);
    tr(1'h0, fsp_pkg::OFF_STATUS, 32'h0, 34'h0);
    wpn <= 1'h1;
    op(2'h0, 5, 1'h0);
    tr(1'h0, fsp_pkg::OFF_FLAGS, 32'h0, 34'h3);
    irqx = 1;
    tr(1'h1, fsp_pkg::OFF_MASK, 32'h2, 34'h0);
    tr(1'h0, fsp_pkg::OFF_MASK, 32'h0, 34'h2);
    irqx = 0;
    tr(1'h1, fsp_pkg::OFF_FLAGS, 32'h3, 34'h0);
    tr(1'h0, fsp_pkg::OFF_FLAGS, 32'h0, 34'h0);
    tr(1'h0, 8'h20, 32'h0, 34'h0);
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : tb_top
bind fsp_top fsp_chk u_chk (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .write_protect_n, .irq, .op_grant, .op_refuse);
